/* File: hw/hdlc_rx_status.sv */
`timescale 1ns/10ps
module hdlc_rx_status
	import hdlc_rx_status_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// byte stream from layer 1 deframer
	input  wire byte_beat_t l1_beat,
	input  wire logic       l1_start,
	input  wire logic       l1_end,
	input  wire logic       l1_abort,
	input  wire logic       l1_octet_ok,
	input  wire logic       l1_crc_ok,
	// byte stream from layer 2 transmitter
	input  wire byte_beat_t l2_tx_beat,
	input  wire logic       l2_tx_start,
	input  wire logic       l2_tx_end,
	input  wire logic       l2_tx_abort,
	input  wire logic       l2_tx_octet_ok,
	input  wire logic       l2_tx_crc_ok,
	input  wire logic       serial_if_active,
	// receive queue
	input  wire logic       queue_full,
	output byte_beat_t      rx_frame_queue,
	output logic            rx_frame_queue_last,
	output logic            rx_queue_release,
	output logic            rx_queue_clear,
	output logic            frame_accepted,
	output logic            rx_message_end_irq
);

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0]    first_service_id_a;
	logic [7:0]    first_service_id_b;
	logic [7:0]    endpoint_id_a;
	logic [7:0]    endpoint_id_b;
	logic [7:0]    layer2_test_control;
	logic [2:0]    transfer_mode_sel;
	frame_status_t rx_frame_status;
	logic [11:0]   rx_count;
	logic          length_exceeded;
	logic [11:0]   len_hold;
	logic          ovf_hold;
	rx_state_t     state;
	logic [1:0]    addr_idx;
	logic [7:0]    addr_first;
	logic [7:0]    addr_second;
	logic          lost;

	wire logic first_byte_mask_en  = first_service_id_a[MASK_BIT];
	wire logic second_byte_mask_en = first_service_id_b[MASK_BIT];
	wire logic layer2_loopback     = layer2_test_control[LOOP_BIT];
	wire logic wr_cmd              = reg_wr && (reg_addr == ADDR_CMD);
	wire logic rx_release_cmd      = wr_cmd && reg_wdata[CMD_RELEASE];
	wire logic rx_reset_cmd        = wr_cmd && reg_wdata[CMD_RESET];

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			first_service_id_a  <= RST_SERVICE;
			first_service_id_b  <= RST_SERVICE;
			endpoint_id_a       <= RST_ENDPT;
			endpoint_id_b       <= RST_ENDPT;
			layer2_test_control <= RST_ZERO;
			transfer_mode_sel   <= RST_MODE;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_SERVICE_A: first_service_id_a  <= reg_wdata;
				ADDR_SERVICE_B: first_service_id_b  <= reg_wdata;
				ADDR_ENDPT_A:   endpoint_id_a       <= reg_wdata;
				ADDR_ENDPT_B:   endpoint_id_b       <= reg_wdata;
				ADDR_TEST:      layer2_test_control <= {7'h00, reg_wdata[LOOP_BIT]};
				ADDR_MODE:      transfer_mode_sel   <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// source select
	// ************************************************************
	// loopback only counts while the serial bus is up
	wire logic        use_loop = layer2_loopback && serial_if_active;
	wire byte_beat_t  in_beat  = use_loop ? l2_tx_beat : l1_beat;
	wire logic        in_start = use_loop ? l2_tx_start : l1_start;
	wire logic        in_end   = use_loop ? l2_tx_end : l1_end;
	wire logic        in_abort = use_loop ? l2_tx_abort : l1_abort;
	wire logic        in_oct   = use_loop ? l2_tx_octet_ok : l1_octet_ok;
	wire logic        in_crc   = use_loop ? l2_tx_crc_ok : l1_crc_ok;

	// ************************************************************
	// address comparison
	// ************************************************************
	// service compare leaves out the command/response bit and bit 0, which holds
	// a mask control in the register and the extension bit on the line
	logic       svc_a, svc_b, svc_g, ep_a, ep_b, ep_g;
	logic [1:0] svc_code;
	logic       ep_flag, accept, is_one, is_two;

	always_comb begin
		svc_g = ((addr_first & SVC_CMP_MSK) == (GROUP_SVC_A & SVC_CMP_MSK))
			|| ((addr_first & SVC_CMP_MSK) == (GROUP_SVC_B & SVC_CMP_MSK));
		ep_g  = (addr_second == GROUP_EP);
		if (first_byte_mask_en) begin
			svc_a = ((addr_first ^ first_service_id_a) & SVC_CMP_MSK
				& ~first_service_id_b) == 8'h00;
			svc_b = 1'b0;
		end else begin
			svc_a = ((addr_first ^ first_service_id_a) & SVC_CMP_MSK) == 8'h00;
			svc_b = ((addr_first ^ first_service_id_b) & SVC_CMP_MSK) == 8'h00;
		end
		if (second_byte_mask_en) begin
			ep_a = ((addr_second ^ endpoint_id_a) & ~endpoint_id_b) == 8'h00;
			ep_b = 1'b0;
		end else begin
			ep_a = addr_second == endpoint_id_a;
			ep_b = addr_second == endpoint_id_b;
		end
		// a wins over b, so equal values never give code 00
		if (svc_a) svc_code = SVC_HIT_A;
		else if (svc_b) svc_code = SVC_HIT_B;
		else if (svc_g) svc_code = SVC_HIT_G;
		else svc_code = SVC_NONE;
		is_one  = transfer_mode_sel == MODE_ONE_BYTE;
		is_two  = transfer_mode_sel == MODE_TWO_BYTE;
		ep_flag = 1'b0;
		accept  = 1'b1;
		case (transfer_mode_sel)
			MODE_ONE_BYTE: begin
				ep_flag = ep_a;
				accept  = ep_a || ep_b;
			end
			MODE_TWO_BYTE: begin
				ep_flag = ep_a || ep_b;
				accept  = (svc_code != SVC_NONE) && (ep_a || ep_b || ep_g);
			end
			MODE_TRN1: accept = svc_code != SVC_NONE;
			MODE_TRN2: begin
				ep_flag = ep_a || ep_b;
				accept  = ep_a || ep_b || ep_g;
			end
			default: accept = 1'b1;
		endcase
	end

	// ************************************************************
	// frame tracking
	// ************************************************************
	wire logic byte_in = in_beat.valid && (state == ST_FRAME);
	// first byte of a one-byte address is the endpoint byte
	wire logic one_addr = is_one;

	always_ff @(posedge sys_clk) begin
		if (srst || rx_reset_cmd) begin
			state       <= ST_IDLE;
			rx_count    <= 12'h000;
			length_exceeded <= 1'b0;
			addr_idx    <= 2'h0;
			addr_first  <= RST_ZERO;
			addr_second <= RST_ZERO;
			lost        <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (in_start) begin
						state           <= ST_FRAME;
						rx_count        <= 12'h000;
						length_exceeded <= 1'b0;
						addr_idx        <= 2'h0;
						lost            <= 1'b0;
					end
				end
				ST_FRAME: begin
					if (byte_in) begin
						if (rx_count == LEN_MAX) length_exceeded <= 1'b1;
						else rx_count <= rx_count + 12'h001;
						if (queue_full) lost <= 1'b1;
						if (addr_idx == 2'h0) begin
							if (one_addr) addr_second <= in_beat.data;
							else addr_first <= in_beat.data;
							addr_idx <= 2'h1;
						end else if (addr_idx == 2'h1) begin
							if (!one_addr) addr_second <= in_beat.data;
							addr_idx <= 2'h2;
						end
					end
					if (in_end || in_abort) state <= ST_HELD;
				end
				ST_HELD: begin
					if (rx_release_cmd) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// status capture and length hold
	// ************************************************************
	wire logic frame_done = (state == ST_FRAME) && (in_end || in_abort);
	frame_status_t next_status;

	always_comb begin
		next_status.frame_valid       = in_oct && !in_abort;
		next_status.rx_bytes_lost     = lost || (byte_in && queue_full);
		next_status.crc_ok            = in_crc && !in_abort;
		next_status.frame_aborted     = in_abort;
		next_status.service_hit_code  = (is_two || transfer_mode_sel == MODE_TRN1)
			? svc_code : SVC_NONE;
		next_status.endpoint_hit_flag = ep_flag;
		next_status.cmd_resp          = addr_first[CR_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_frame_status <= RST_STATUS;
		end else if (frame_done) begin
			rx_frame_status <= next_status;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || rx_reset_cmd) begin
			len_hold <= 12'h000;
			ovf_hold <= 1'b0;
		end else if (frame_done) begin
			// a stray release in the closing cycle must not lose the new length
			len_hold <= rx_count;
			ovf_hold <= length_exceeded || (byte_in && rx_count == LEN_MAX);
		end else if (rx_release_cmd) begin
			len_hold <= 12'h000;
			ovf_hold <= 1'b0;
		end
	end

	// ************************************************************
	// receive queue outputs
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_frame_queue      <= '0;
			rx_frame_queue_last <= 1'b0;
			rx_queue_release    <= 1'b0;
			rx_queue_clear      <= 1'b0;
			frame_accepted      <= 1'b0;
			rx_message_end_irq  <= 1'b0;
		end else begin
			rx_queue_release   <= rx_release_cmd && (state == ST_HELD);
			rx_queue_clear     <= rx_reset_cmd;
			rx_message_end_irq <= frame_done && !rx_reset_cmd;
			if (frame_done) begin
				rx_frame_queue      <= '{valid: 1'b1, data: next_status};
				rx_frame_queue_last <= 1'b1;
				frame_accepted      <= accept;
			end else begin
				rx_frame_queue      <= '{valid: byte_in && !queue_full, data: in_beat.data};
				rx_frame_queue_last <= 1'b0;
			end
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_SERVICE_A: reg_rdata <= first_service_id_a;
				ADDR_SERVICE_B: reg_rdata <= first_service_id_b;
				ADDR_LEN_LOW:   reg_rdata <= len_hold[7:0];
				ADDR_LEN_HIGH:  reg_rdata <= {3'h0, ovf_hold, len_hold[11:8]};
				ADDR_ENDPT_A:   reg_rdata <= endpoint_id_a;
				ADDR_ENDPT_B:   reg_rdata <= endpoint_id_b;
				ADDR_STATUS:    reg_rdata <= rx_frame_status;
				ADDR_MODE:      reg_rdata <= {5'h00, transfer_mode_sel};
				ADDR_TEST:      reg_rdata <= layer2_test_control;
				default:        reg_rdata <= RST_ZERO;
			endcase
		end else begin
			reg_rdata <= RST_ZERO;
		end
	end

endmodule

/* File: hw/hdlc_rx_status_pkg.sv */
package hdlc_rx_status_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_SERVICE_A = 8'h20;
	localparam logic [7:0] ADDR_SERVICE_B = 8'h21;
	localparam logic [7:0] ADDR_LEN_LOW   = 8'h22;
	localparam logic [7:0] ADDR_LEN_HIGH  = 8'h23;
	localparam logic [7:0] ADDR_ENDPT_A   = 8'h24;
	localparam logic [7:0] ADDR_ENDPT_B   = 8'h25;
	localparam logic [7:0] ADDR_STATUS    = 8'h26;
	localparam logic [7:0] ADDR_CMD       = 8'h27;
	localparam logic [7:0] ADDR_MODE      = 8'h28;
	localparam logic [7:0] ADDR_TEST      = 8'h29;

	// ************************************************************
	// reset values and fixed identifiers
	// ************************************************************
	localparam logic [7:0] RST_SERVICE = 8'hfc;
	localparam logic [7:0] RST_ENDPT   = 8'hff;
	localparam logic [7:0] RST_STATUS  = 8'h0f;
	localparam logic [7:0] RST_ZERO    = 8'h00;
	localparam logic [2:0] RST_MODE    = 3'h2;
	localparam logic [7:0] GROUP_SVC_A = 8'hfc;
	localparam logic [7:0] GROUP_SVC_B = 8'hfe;
	localparam logic [7:0] GROUP_EP    = 8'hff;
	localparam logic [7:0] SVC_CMP_MSK = 8'hfc;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int MASK_BIT    = 0;
	localparam int CMD_RELEASE = 7;
	localparam int CMD_RESET   = 6;
	localparam int LOOP_BIT    = 0;
	localparam int CR_BIT      = 1;
	localparam int LEN_W       = 12;
	localparam logic [11:0] LEN_MAX = 12'hfff;

	// ************************************************************
	// modes and codes
	// ************************************************************
	localparam logic [2:0] MODE_ONE_BYTE = 3'h2;
	localparam logic [2:0] MODE_TWO_BYTE = 3'h3;
	localparam logic [2:0] MODE_EXT_TRN  = 3'h4;
	localparam logic [2:0] MODE_TRN2     = 3'h5;
	localparam logic [2:0] MODE_TRN0     = 3'h6;
	localparam logic [2:0] MODE_TRN1     = 3'h7;
	localparam logic [1:0] SVC_HIT_A     = 2'h2;
	localparam logic [1:0] SVC_HIT_B     = 2'h0;
	localparam logic [1:0] SVC_HIT_G     = 2'h1;
	localparam logic [1:0] SVC_NONE      = 2'h3;

	typedef struct packed {
		logic       frame_valid;
		logic       rx_bytes_lost;
		logic       crc_ok;
		logic       frame_aborted;
		logic [1:0] service_hit_code;
		logic       endpoint_hit_flag;
		logic       cmd_resp;
	} frame_status_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_beat_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FRAME,
		ST_HELD
	} rx_state_t;

endpackage

/* File: verification/hdlc_rx_status_props.sv */
`timescale 1ns/10ps
// ********
// status checks
// ********
module hdlc_rx_status_props
	import hdlc_rx_status_pkg::*;
(
	// clock, reset, registers
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	// frame sources
	input wire byte_beat_t l1_beat,
	input wire logic       l1_end,
	input wire logic       l1_abort,
	input wire logic       l1_octet_ok,
	input wire logic       l1_crc_ok,
	input wire byte_beat_t l2_tx_beat,
	input wire logic       l2_tx_end,
	input wire logic       l2_tx_abort,
	input wire logic       l2_tx_octet_ok,
	input wire logic       l2_tx_crc_ok,
	input wire logic       serial_if_active,
	// receive queue
	input wire logic       queue_full,
	input wire byte_beat_t rx_frame_queue,
	input wire logic       rx_frame_queue_last,
	input wire logic       rx_queue_clear,
	input wire logic       rx_message_end_irq
);
	logic loop_on;
	logic use_l2;
	logic ended;
	logic crc_s;
	logic ab_s;
	logic oct_s;
	// shadow of the loop bit, the register itself is not visible here
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			loop_on <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_TEST) begin
			loop_on <= reg_wdata[LOOP_BIT];
		end
	end
	assign use_l2 = loop_on && serial_if_active;
	assign ended = use_l2 ? (l2_tx_end || l2_tx_abort) : (l1_end || l1_abort);
	assign crc_s = use_l2 ? l2_tx_crc_ok : l1_crc_ok;
	assign ab_s = use_l2 ? l2_tx_abort : l1_abort;
	assign oct_s = use_l2 ? l2_tx_octet_ok : l1_octet_ok;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence s_status;
		rx_frame_queue_last && rx_frame_queue.valid;
	endsequence
	sequence s_clear_pulse;
		rx_queue_clear ##1 !rx_queue_clear;
	endsequence
	AST_IRQ_CAUSE: assert property (rx_message_end_irq |-> $past(ended))
		else $error("end irq without frame end");
	AST_STATUS_BEAT: assert property (rx_message_end_irq |-> s_status)
		else $error("no status beat with end irq");
	// an aborted frame always reports a failed checksum
	AST_CRC_COPY: assert property (s_status
		|-> rx_frame_queue.data[5] == ($past(crc_s) && !$past(ab_s)))
		else $error("checksum bit wrong");
	AST_ABORT_COPY: assert property (s_status |-> rx_frame_queue.data[4] == $past(ab_s))
		else $error("abort bit wrong");
	AST_VALID_COPY: assert property (s_status ##0 !rx_frame_queue.data[4]
		|-> rx_frame_queue.data[7] == $past(oct_s))
		else $error("valid bit wrong");
	AST_FULL_DROP: assert property ((l1_beat.valid || l2_tx_beat.valid)
		&& queue_full && !ended |=> !rx_frame_queue.valid)
		else $error("byte forwarded while queue full");
	AST_LOOP_BLOCK: assert property (use_l2 && l1_beat.valid && !l2_tx_beat.valid
		&& !ended |=> !rx_frame_queue.valid)
		else $error("layer 1 byte passed during loop");
	AST_CLEAR_CMD: assert property (reg_wr && reg_addr == ADDR_CMD
		&& reg_wdata[CMD_RESET] |=> s_clear_pulse)
		else $error("no clear pulse after receiver reset");
endmodule
bind hdlc_rx_status hdlc_rx_status_props u_props (
	.sys_clk             (sys_clk),
	.srst                (srst),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_wr              (reg_wr),
	.l1_beat             (l1_beat),
	.l1_end              (l1_end),
	.l1_abort            (l1_abort),
	.l1_octet_ok         (l1_octet_ok),
	.l1_crc_ok           (l1_crc_ok),
	.l2_tx_beat          (l2_tx_beat),
	.l2_tx_end           (l2_tx_end),
	.l2_tx_abort         (l2_tx_abort),
	.l2_tx_octet_ok      (l2_tx_octet_ok),
	.l2_tx_crc_ok        (l2_tx_crc_ok),
	.serial_if_active    (serial_if_active),
	.queue_full          (queue_full),
	.rx_frame_queue      (rx_frame_queue),
	.rx_frame_queue_last (rx_frame_queue_last),
	.rx_queue_clear      (rx_queue_clear),
	.rx_message_end_irq  (rx_message_end_irq)
);

/* File: verification/hdlc_frame_src.sv */
`timescale 1ns/10ps
// ********
// deframed byte source
// ********
module hdlc_frame_src
	import hdlc_rx_status_pkg::*;
(
	// clock
	input  wire logic sys_clk,
	// frame stream
	output byte_beat_t beat,
	output logic       start,
	output logic       fin,
	output logic       abrt,
	output logic       octet_ok,
	output logic       crc_ok
);
	initial begin
		beat = '0;
		{start, fin, abrt, octet_ok, crc_ok} = 5'b00000;
	end
	// idle data shows the inverse so a stale byte is never mistaken for a fresh one
	task automatic send(input logic [7:0] q[$], input int gap, input logic ok,
		input logic crc, input logic ab);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		foreach (q[i]) begin
			beat <= '{1'b1, q[i]};
			@(posedge sys_clk);
			if (gap > 0) begin
				beat <= '{1'b0, ~q[i]};
				repeat (gap) @(posedge sys_clk);
			end
		end
		beat <= '{1'b0, ~q[$]};
		octet_ok <= ok;
		crc_ok <= crc;
		if (ab) begin
			abrt <= 1'b1;
		end else begin
			fin <= 1'b1;
		end
		@(posedge sys_clk);
		{fin, abrt} <= 2'b00;
	endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench import hdlc_rx_status_pkg::*;;
	logic       sys_clk = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       serial_if_active = 1'b0;
	logic       queue_full = 1'b0;
	logic [7:0] reg_rdata, st;
	byte_beat_t l1_beat, l2_tx_beat, rx_frame_queue;
	logic       l1_start, l1_end, l1_abort, l1_octet_ok, l1_crc_ok;
	logic       l2_tx_start, l2_tx_end, l2_tx_abort, l2_tx_octet_ok, l2_tx_crc_ok;
	logic       rx_frame_queue_last, rx_queue_release, rx_queue_clear;
	logic       frame_accepted, rx_message_end_irq;
	int         errors = 0, compares = 0, n_st = 0, n_rel = 0, n_clr = 0, n_dat = 0, n_irq = 0;
	// {mask, mode, svc a, svc b, endpt a, endpt b, byte 0, byte 1, expected status[3:0]}
	logic [63:0] tbl [13] = '{64'hf310_2003_0510_030a, 64'hf310_2003_0520_0502,
		64'hf310_2003_05fc_ff04, 64'hf310_2003_0512_ff09, 64'hf310_2003_05fe_0307,
		64'he210_2003_0503_5a0e, 64'he210_2003_0505_5a0c, 64'hc710_2003_0520_5a00,
		64'h2510_2003_0544_ff00, 64'hf310_1003_0510_ff08, 64'hf311_0d03_0f1c_0b0a,
		64'h0610_2003_0577_7700, 64'h2410_2003_0503_5a00};

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (rx_frame_queue_last) begin
			st <= rx_frame_queue.data;
			n_st <= n_st + 1;
		end
		n_rel <= n_rel + int'(rx_queue_release);
		n_clr <= n_clr + int'(rx_queue_clear);
		n_dat <= n_dat + int'(rx_frame_queue.valid && !rx_frame_queue_last);
		n_irq <= n_irq + int'(rx_message_end_irq);
	end

	hdlc_frame_src u_l1 (.sys_clk(sys_clk), .beat(l1_beat), .start(l1_start), .fin(l1_end),
		.abrt(l1_abort), .octet_ok(l1_octet_ok), .crc_ok(l1_crc_ok));
	hdlc_frame_src u_l2 (.sys_clk(sys_clk), .beat(l2_tx_beat), .start(l2_tx_start),
		.fin(l2_tx_end), .abrt(l2_tx_abort), .octet_ok(l2_tx_octet_ok), .crc_ok(l2_tx_crc_ok));
	hdlc_rx_status u_dut (
		.sys_clk             (sys_clk),
		.srst                (srst),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.l1_beat             (l1_beat),
		.l1_start            (l1_start),
		.l1_end              (l1_end),
		.l1_abort            (l1_abort),
		.l1_octet_ok         (l1_octet_ok),
		.l1_crc_ok           (l1_crc_ok),
		.l2_tx_beat          (l2_tx_beat),
		.l2_tx_start         (l2_tx_start),
		.l2_tx_end           (l2_tx_end),
		.l2_tx_abort         (l2_tx_abort),
		.l2_tx_octet_ok      (l2_tx_octet_ok),
		.l2_tx_crc_ok        (l2_tx_crc_ok),
		.serial_if_active    (serial_if_active),
		.queue_full          (queue_full),
		.rx_frame_queue      (rx_frame_queue),
		.rx_frame_queue_last (rx_frame_queue_last),
		.rx_queue_release    (rx_queue_release),
		.rx_queue_clear      (rx_queue_clear),
		.frame_accepted      (frame_accepted),
		.rx_message_end_irq  (rx_message_end_irq)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
		@(posedge sys_clk);
		check(v, e);
	endtask
	task automatic go(input logic [7:0] q[$], input logic lp, input int gap, input logic ok,
		input logic ab);
		if (lp) begin
			u_l2.send(q, gap, ok, ok, ab);
		end else begin
			u_l1.send(q, gap, ok, ok, ab);
		end
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic rel();
		int k;
		k = n_rel;
		wr(ADDR_CMD, 8'h80);
		@(posedge sys_clk);
		check(8'(n_rel - k), 8'h01);
	endtask
	task automatic t_regs();
		logic [7:0] ra [10] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h30};
		logic [7:0] re [10] = '{8'hfc, 8'hfc, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f, 8'h02, 8'h00, 8'h00};
		wr(ADDR_LEN_LOW, 8'h55);
		for (int i = 0; i < 10; i++) begin
			chk_reg(ra[i], re[i]);
		end
	endtask
	task automatic t_addr();
		for (int i = 0; i < 13; i++) begin
			wr(ADDR_MODE, {5'b0, tbl[i][58:56]});
			wr(ADDR_SERVICE_A, tbl[i][55:48]);
			wr(ADDR_SERVICE_B, tbl[i][47:40]);
			wr(ADDR_ENDPT_A, tbl[i][39:32]);
			wr(ADDR_ENDPT_B, tbl[i][31:24]);
			go('{tbl[i][23:16], tbl[i][15:8]}, 1'b0, 0, 1'b1, 1'b0);
			check(st & {4'h0, tbl[i][63:60]}, tbl[i][7:0]);
			check({4'h0, st[7:4]}, 8'h0a);
			check({7'b0, frame_accepted}, 8'h01);
			rel();
		end
	endtask
	task automatic t_err();
		logic [7:0] q [$];
		int n;
		int d;
		wr(ADDR_MODE, {5'b0, MODE_TWO_BYTE});
		queue_full <= 1'b1;
		d = n_dat;
		go('{8'h10, 8'h03, 8'h01}, 1'b0, 0, 1'b1, 1'b0);
		queue_full <= 1'b0;
		check({7'b0, st[6]}, 8'h01);
		check(8'(n_dat - d), 8'h00);
		rel();
		go('{8'h10, 8'h03}, 1'b0, 0, 1'b0, 1'b0);
		check({6'b0, st[7], st[5]}, 8'h00);
		check(8'(n_dat - d), 8'h02);
		rel();
		go('{8'h10, 8'h03}, 1'b0, 0, 1'b1, 1'b1);
		check({7'b0, st[4]}, 8'h01);
		rel();
		for (int i = 0; i < 4097; i++) begin
			q.push_back(i[7:0]);
		end
		go(q, 1'b0, 0, 1'b1, 1'b0);
		check({7'b0, frame_accepted}, 8'h00);
		check(st & 8'h0f, 8'h0c);
		chk_reg(ADDR_LEN_LOW, 8'hff);
		n = n_st;
		go('{8'h10, 8'h03}, 1'b0, 0, 1'b1, 1'b0);
		check(8'(n_st - n), 8'h00);
		chk_reg(ADDR_LEN_HIGH, 8'h1f);
		wr(ADDR_CMD, 8'h40);
		@(posedge sys_clk);
		check(8'(n_clr), 8'h01);
		go('{8'h10, 8'h03, 8'h01}, 1'b0, 3, 1'b1, 1'b0);
		check(8'(n_st - n), 8'h01);
		chk_reg(ADDR_LEN_LOW, 8'h03);
		rel();
	endtask
	task automatic t_loop();
		int n;
		n = n_st;
		wr(ADDR_TEST, 8'h01);
		serial_if_active <= 1'b1;
		go('{8'h10, 8'h03}, 1'b0, 0, 1'b1, 1'b0);
		check(8'(n_st - n), 8'h00);
		go('{8'h10, 8'h03}, 1'b1, 2, 1'b1, 1'b0);
		check(8'(n_st - n), 8'h01);
		rel();
		serial_if_active <= 1'b0;
		go('{8'h10, 8'h03}, 1'b0, 0, 1'b1, 1'b0);
		check(8'(n_st - n), 8'h02);
		rel();
		check(8'(n_irq - n_st), 8'h00);
	endtask
	task automatic print_verdict();
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs();
		t_addr();
		t_err();
		t_loop();
		print_verdict();
	end
	// run needs about 4500 cycles, so this only trips on a hang
	initial begin
		#300000;
		errors++;
		print_verdict();
	end
endmodule
